// ### adc_readout_timing.sv
// Purpose: Conversion sequencing, busy flag and parallel or master serial result readout.
// Assumes: Pins are synchronous to clock; conv_sample is stable at conversion end.
// Notes: Results pass a two-entry buffer; a full buffer holds busy until a reader drains it.
`timescale 1ns/100ps
module adc_readout_timing (
	input wire logic clock, // 100 MHz clock
	input wire logic reset, // Synchronous reset
	input wire logic adc_reset, // Device reset pin, active high
	input wire logic convert_start_n, // Start strobe, falling edge
	input wire adc_timing_pkg::mode_t mode, // Readout mode
	input wire logic read_during_convert, // Serial frame during next conversion
	input wire logic [1:0] serial_clock_divider, // Read-after-convert clock divider
	input wire logic cs_n, // Chip select, active low
	input wire logic rd_n, // Parallel read, active low
	input wire logic [1:0] word_select, // Word or byte select in narrow modes
	input wire adc_timing_pkg::sample_t conv_sample, // Result from converter core
	output logic busy, // Conversion or reset in progress
	output adc_timing_pkg::sample_t data_out, // Parallel data bus
	output logic data_oe, // Parallel bus drive enable
	output logic frame_sync_out, // Serial frame sync
	output logic frame_sync_oe, // Frame sync drive enable
	output logic sclk_out, // Serial clock
	output logic sclk_oe, // Serial clock drive enable
	output logic serial_data_out, // Serial data
	output logic serial_data_oe // Serial data drive enable
);
	import adc_timing_pkg::*;

	conv_state_e conv_state_reg, conv_state_next; // Sequencer
	count_t conv_cnt_reg, conv_cnt_next; // Conversion or reset counter
	logic busy_reg, busy_next; // Busy flag
	logic start_prev_reg, start_prev_next; // Last strobe level
	ser_state_e ser_state_reg, ser_state_next; // Serial frame
	sample_t shift_reg, shift_next; // Serial shifter
	logic [4:0] bit_cnt_reg, bit_cnt_next; // Bits sent
	logic sync_reg, sync_next; // Frame sync
	logic sclk_reg, sclk_next; // Serial clock level
	logic sdo_reg, sdo_next; // Serial data bit
	logic frame_done_reg, frame_done_next; // Pulse as sync drops
	logic ser_oe_reg, ser_oe_next; // Serial drivers on
	sample_t word_reg, word_next; // Last parallel result
	sample_t data_reg, data_next; // Parallel bus value
	logic data_oe_reg, data_oe_next; // Parallel drivers on
	logic start_fall, parallel, serial, rac; // Decoded conditions
	logic push, buf_in_ready, buf_out_valid, buf_out_ready; // Buffer handshakes
	sample_t buf_out_data; // Buffer head
	logic par_pop, ser_pop, tick, restart_tick; // Readout events
	half_t half_sel; // Serial clock pacing

	assign parallel = (mode != MODE_SERIAL);
	assign serial = (mode == MODE_SERIAL);
	assign rac = serial & ~read_during_convert;
	assign start_fall = start_prev_reg & ~convert_start_n;
	assign par_pop = parallel & buf_out_valid;
	assign buf_out_ready = par_pop | ser_pop;

	// Results wait here so a slow reader loses nothing
	two_entry_buffer #(.WIDTH(DATA_BITS), .DEPTH(2)) result_buf (
		.clock(clock),
		.reset(reset),
		.in_data(conv_sample),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.out_data(buf_out_data),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready)
	);

	// Serial clock pacing; read-during-convert runs at the fastest rate
	always_comb begin
		case (serial_clock_divider)
			2'h0: half_sel = HALF_DIV0;
			2'h1: half_sel = HALF_DIV1;
			2'h2: half_sel = HALF_DIV2;
			default: half_sel = HALF_DIV3;
		endcase
		if (!rac) begin
			half_sel = HALF_RDC;
		end
	end

	assign restart_tick = (ser_state_reg != S_SHIFT);

	half_period_timer sclk_timer (
		.clock(clock),
		.reset(reset),
		.restart(restart_tick),
		.half_cycles(half_sel),
		.tick(tick)
	);

	// Conversion sequencer and busy flag
	always_comb begin
		conv_state_next = conv_state_reg;
		conv_cnt_next = conv_cnt_reg;
		busy_next = busy_reg;
		start_prev_next = convert_start_n;
		push = 1'b0;
		if (adc_reset) begin
			// Device reset wins over everything and raises busy next edge
			conv_state_next = C_RESET;
			conv_cnt_next = '0;
			busy_next = 1'b1;
		end else begin
			case (conv_state_reg)
				C_IDLE: begin
					// Starts while busy are ignored
					if (start_fall) begin
						conv_state_next = C_CONV;
						conv_cnt_next = '0;
						busy_next = 1'b1;
					end
				end
				C_CONV: begin
					if (conv_cnt_reg == count_t'(CONV_CYC - 1)) begin
						conv_state_next = C_PUSH;
					end else begin
						conv_cnt_next = conv_cnt_reg + 1'b1;
					end
				end
				C_PUSH: begin
					// Conversion ends here; busy is held at least one more cycle
					push = 1'b1;
					if (buf_in_ready) begin
						if (rac) begin
							conv_state_next = C_WAIT_FRAME;
						end else if (parallel) begin
							conv_state_next = C_WAIT_DATA;
						end else begin
							conv_state_next = C_SETTLE;
						end
					end
				end
				C_WAIT_DATA: begin
					// Data lands on the bus as it leaves the buffer
					if (par_pop) begin
						conv_state_next = C_SETTLE;
					end
				end
				C_WAIT_FRAME: begin
					// Busy drops one cycle after sync falls
					if (frame_done_reg) begin
						conv_state_next = C_IDLE;
						busy_next = 1'b0;
					end
				end
				C_SETTLE: begin
					conv_state_next = C_IDLE;
					busy_next = 1'b0;
				end
				C_RESET: begin
					if (conv_cnt_reg == count_t'(RESET_HOLD_CYC - 1)) begin
						conv_state_next = C_IDLE;
						busy_next = 1'b0;
					end else begin
						conv_cnt_next = conv_cnt_reg + 1'b1;
					end
				end
				default: begin
					conv_state_next = C_IDLE;
					busy_next = 1'b0;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clock) begin
		if (reset) begin
			conv_state_reg <= C_IDLE;
			conv_cnt_reg <= '0;
			busy_reg <= 1'b0;
			start_prev_reg <= 1'b1;
		end else begin
			conv_state_reg <= conv_state_next;
			conv_cnt_reg <= conv_cnt_next;
			busy_reg <= busy_next;
			start_prev_reg <= start_prev_next;
		end
	end

	// Master serial frame: sync, then 18 clocks, MSB first, data changes on falling edges
	always_comb begin
		ser_state_next = ser_state_reg;
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		sync_next = sync_reg;
		sclk_next = sclk_reg;
		sdo_next = sdo_reg;
		frame_done_next = 1'b0;
		ser_pop = 1'b0;
		ser_oe_next = serial & ~cs_n;
		case (ser_state_reg)
			S_IDLE: begin
				if (serial && !cs_n && buf_out_valid && !adc_reset &&
					((!rac && conv_state_reg == C_CONV &&
					conv_cnt_reg == count_t'(SYNC_RDC_CYC - 1)) ||
					(rac && conv_state_reg == C_WAIT_FRAME))) begin
					ser_pop = 1'b1;
					shift_next = buf_out_data;
					sdo_next = buf_out_data[DATA_BITS-1];
					sync_next = 1'b1;
					bit_cnt_next = '0;
					ser_state_next = S_SYNC;
				end
			end
			S_SYNC: begin
				// One clear cycle between sync and the shift state; the first clock edge follows one half period later
				ser_state_next = S_SHIFT;
			end
			S_SHIFT: begin
				if (cs_n) begin
					// Deselect abandons the frame
					sync_next = 1'b0;
					sclk_next = 1'b0;
					frame_done_next = 1'b1;
					ser_state_next = S_IDLE;
				end else if (tick) begin
					sclk_next = ~sclk_reg;
					if (sclk_reg) begin
						shift_next = {shift_reg[DATA_BITS-2:0], 1'b0};
						sdo_next = shift_reg[DATA_BITS-2];
						bit_cnt_next = bit_cnt_reg + 1'b1;
						if (bit_cnt_reg == 5'(DATA_BITS - 1)) begin
							sync_next = 1'b0;
							frame_done_next = 1'b1;
							ser_state_next = S_IDLE;
						end
					end
				end
			end
			default: begin
				ser_state_next = S_IDLE;
			end
		endcase
	end

	// Serial registers
	always_ff @(posedge clock) begin
		if (reset) begin
			ser_state_reg <= S_IDLE;
			shift_reg <= '0;
			bit_cnt_reg <= '0;
			sync_reg <= 1'b0;
			sclk_reg <= 1'b0;
			sdo_reg <= 1'b0;
			frame_done_reg <= 1'b0;
			ser_oe_reg <= 1'b0;
		end else begin
			ser_state_reg <= ser_state_next;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			sync_reg <= sync_next;
			sclk_reg <= sclk_next;
			sdo_reg <= sdo_next;
			frame_done_reg <= frame_done_next;
			ser_oe_reg <= ser_oe_next;
		end
	end

	// Parallel bus: word or byte picked from the last result
	always_comb begin
		word_next = par_pop ? buf_out_data : word_reg;
		case (mode)
			MODE_PAR16: data_next = word_select[0] ?
				{word_next[1:0], 16'h0000} >> 2 : {2'h0, word_next[17:2]};
			MODE_BYTE: begin
				if (word_select == 2'h0) begin
					data_next = {10'h000, word_next[17:10]};
				end else if (word_select == 2'h1) begin
					data_next = {10'h000, word_next[9:2]};
				end else begin
					data_next = {10'h000, word_next[1:0], 6'h00};
				end
			end
			default: data_next = word_next;
		endcase
		data_oe_next = parallel & ~cs_n & ~rd_n;
	end

	// Parallel registers
	always_ff @(posedge clock) begin
		if (reset) begin
			word_reg <= '0;
			data_reg <= '0;
			data_oe_reg <= 1'b0;
		end else begin
			word_reg <= word_next;
			data_reg <= data_next;
			data_oe_reg <= data_oe_next;
		end
	end

	assign busy = busy_reg;
	assign data_out = data_reg;
	assign data_oe = data_oe_reg;
	assign frame_sync_out = sync_reg;
	assign frame_sync_oe = ser_oe_reg;
	assign sclk_out = sclk_reg;
	assign sclk_oe = ser_oe_reg;
	assign serial_data_out = sdo_reg;
	assign serial_data_oe = ser_oe_reg;

	// Checking helpers: busy length and serial clock run length
	localparam int BUSY_LIMIT = BUSY_MAX_CYC;
	localparam int DV_LIMIT = DATA_VALID_CYC;
	localparam int LEN_W = 10; // Wide enough for the slowest read-after-convert busy
	logic [LEN_W-1:0] busy_len_reg; // Cycles busy has been high
	logic [3:0] run_reg; // Cycles since last serial clock change
	logic [LEN_W-1:0] rac_limit; // Busy limit for the divider
	always_ff @(posedge clock) begin
		if (reset) begin
			busy_len_reg <= '0;
			run_reg <= '0;
		end else begin
			busy_len_reg <= busy_reg ? busy_len_reg + 1'b1 : '0;
			// Restart with the pacing timer so the first half period is measured true
			run_reg <= (sclk_next != sclk_reg || restart_tick) ? '0 : run_reg + 1'b1;
		end
	end
	always_comb begin
		case (serial_clock_divider)
			2'h0: rac_limit = LEN_W'(RAC_BUSY0_NS / CLOCK_PERIOD_NS);
			2'h1: rac_limit = LEN_W'(RAC_BUSY1_NS / CLOCK_PERIOD_NS);
			2'h2: rac_limit = LEN_W'(RAC_BUSY2_NS / CLOCK_PERIOD_NS);
			default: rac_limit = LEN_W'(RAC_BUSY3_NS / CLOCK_PERIOD_NS);
		endcase
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	property p_busy_max;
		(parallel && !adc_reset) |-> busy_len_reg <= LEN_W'(BUSY_LIMIT);
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy too long");

	property p_busy_after_end;
		(conv_state_reg == C_PUSH && buf_in_ready && !adc_reset) |=>
			busy ##1 (busy == (parallel || rac));
	endproperty
	a_busy_after_end: assert property (p_busy_after_end) else $error("busy fell early");

	property p_reset_busy;
		adc_reset |=> busy;
	endproperty
	a_reset_busy: assert property (p_reset_busy) else $error("reset left busy low");

	property p_reset_release;
		(conv_state_reg == C_RESET && !adc_reset &&
			conv_cnt_reg == count_t'(RESET_HOLD_CYC - 1)) |-> busy ##1 !busy;
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("reset hold wrong");

	sequence s_par_start;
		conv_state_reg == C_IDLE && start_fall && parallel && !adc_reset && buf_in_ready;
	endsequence
	property p_data_valid;
		s_par_start ##1 (parallel && !adc_reset)[*1] |-> ##[1:DV_LIMIT] par_pop;
	endproperty
	a_data_valid: assert property (p_data_valid) else $error("parallel data late");

	property p_data_before_busy;
		($fell(busy) && parallel && $past(conv_state_reg) == C_SETTLE) |-> $past(par_pop, 2);
	endproperty
	a_data_before_busy: assert property (p_data_before_busy) else $error("data not settled");

	property p_bus_access;
		(parallel && !cs_n && !rd_n) |=> data_oe;
	endproperty
	a_bus_access: assert property (p_bus_access) else $error("bus not driven");

	property p_select_drive;
		(serial && !cs_n) |=> sclk_oe && frame_sync_oe && serial_data_oe;
	endproperty
	a_select_drive: assert property (p_select_drive) else $error("serial not driven");

	property p_deselect_float;
		cs_n |=> !frame_sync_oe && !sclk_oe && !serial_data_oe;
	endproperty
	a_deselect_float: assert property (p_deselect_float) else $error("serial not floated");

	property p_rdc_sync;
		($rose(frame_sync_out) && !rac) |-> conv_cnt_reg == count_t'(SYNC_RDC_CYC);
	endproperty
	a_rdc_sync: assert property (p_rdc_sync) else $error("sync time wrong");

	property p_first_edge;
		$rose(frame_sync_out) |-> !sclk_out ##1 !sclk_out;
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("clock edge too soon");

	property p_rac_sync;
		($rose(frame_sync_out) && rac) |-> $past(conv_state_reg) == C_WAIT_FRAME;
	endproperty
	a_rac_sync: assert property (p_rac_sync) else $error("sync before end");

	property p_rac_busy_drop;
		(frame_done_reg && conv_state_reg == C_WAIT_FRAME && !adc_reset) |=> !busy;
	endproperty
	a_rac_busy_drop: assert property (p_rac_busy_drop) else $error("busy drop late");

	property p_sclk_half;
		(ser_state_reg == S_SHIFT && !cs_n && sclk_next != sclk_reg) |->
			run_reg == half_sel - 1'b1;
	endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("clock half period wrong");

	property p_rac_busy_max;
		(rac && busy && !adc_reset && conv_state_reg != C_RESET) |-> busy_len_reg <= rac_limit;
	endproperty
	a_rac_busy_max: assert property (p_rac_busy_max) else $error("busy too long");

endmodule : adc_readout_timing

// ### adc_readout_timing_test.sv
// Purpose: Self-checking bench for the converter sequencing and readout block.
// Assumes: 100 MHz clock; inputs change by non-blocking assignment at rising edges.
// Notes: Serial words are checked against a queue of results not yet read.
`timescale 1ns/100ps
module adc_readout_timing_test;
	import adc_timing_pkg::*;
	logic clock, reset, adc_reset, convert_start_n, read_during_convert, cs_n, rd_n;
	mode_t mode; // Readout mode, static per test
	logic [1:0] serial_clock_divider, word_select;
	sample_t conv_sample, data_out, host_word, last_data, cur;
	logic busy, data_oe, frame_sync_out, frame_sync_oe, sclk_out, sclk_oe;
	logic serial_data_out, serial_data_oe, host_valid;
	int host_period, host_lead, n_busy, n_sync, n_sync_end, seed;
	int error_cnt = 0; // Mismatches
	int compares = 0; // Comparisons made
	int cycles = 0; // Hang guard
	sample_t expect_q[$]; // Serial results not yet read
	int pmin[4] = '{8, 16, 32, 64}; // Period bands in ns per divider
	int pmax[4] = '{20, 40, 70, 135};
	int bmax[4] = '{840, 1140, 1720, 2880}; // Busy ceilings in ns

	adc_readout_timing dut (.clock, .reset, .adc_reset, .convert_start_n, .mode,
		.read_during_convert, .serial_clock_divider, .cs_n, .rd_n, .word_select,
		.conv_sample, .busy, .data_out, .data_oe, .frame_sync_out, .frame_sync_oe,
		.sclk_out, .sclk_oe, .serial_data_out, .serial_data_oe);
	// Floated serial pins read as the inverse, so a stale level is never trusted
	serial_host host (.clock(clock), .reset(reset),
		.sync(frame_sync_oe ? frame_sync_out : ~frame_sync_out),
		.sclk(sclk_oe ? sclk_out : ~sclk_out),
		.sdata(serial_data_oe ? serial_data_out : ~serial_data_out),
		.word(host_word), .word_valid(host_valid),
		.period(host_period), .lead(host_lead));

	task automatic summarize();
		if (error_cnt == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic chk_word(input string what, input sample_t exp, input sample_t got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_range(input string what, input int lo, input int hi, input int got);
		compares++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
		end
	endtask : chk_range

	// Bus packing per mode and word select
	function automatic sample_t pack(input int m, input int ws, input sample_t r);
		case (m)
			1: pack = (ws == 0) ? {2'h0, r[17:2]} : {2'h0, r[1:0], 14'h0};
			2: pack = (ws == 0) ? {10'h0, r[17:10]} : (ws == 1) ? {10'h0, r[9:2]}
				: {10'h0, r[1:0], 6'h0};
			default: pack = r;
		endcase
	endfunction : pack

	// One conversion; records busy length and sync span in cycles after the start edge
	task automatic convert(input int limit);
		cur = sample_t'($random(seed));
		@(posedge clock);
		conv_sample <= cur;
		convert_start_n <= 1'b0;
		if (mode == MODE_SERIAL) begin
			expect_q.push_back(cur);
		end
		@(posedge clock);
		convert_start_n <= 1'b1;
		n_busy = 0;
		n_sync = 0;
		n_sync_end = 0;
		for (int i = 1; i < limit; i++) begin
			@(negedge clock);
			if (busy === 1'b1) begin
				n_busy = i;
				last_data = data_out;
			end
			if (frame_sync_out === 1'b1) begin
				n_sync_end = i;
				if (n_sync == 0) begin
					n_sync = i;
				end
			end
		end
	endtask : convert

	// Every complete frame carries the oldest unread result
	always @(posedge clock) begin
		if (host_valid === 1'b1) begin
			chk_word("serial word", expect_q.pop_front(), host_word);
		end
	end

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Hang guard, well above the planned run
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		seed = 32'h77fa_256f;
		reset = 1'b1;
		adc_reset = 1'b0;
		convert_start_n = 1'b1;
		mode = MODE_PAR18;
		read_during_convert = 1'b0;
		serial_clock_divider = 2'h0;
		cs_n = 1'b0;
		rd_n = 1'b1;
		word_select = 2'h0;
		conv_sample = 18'h0;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		// Device reset pin raises busy and holds it after release
		@(posedge clock);
		adc_reset <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		chk_word("busy on device reset", 18'h1, busy);
		@(posedge clock);
		adc_reset <= 1'b0;
		n_busy = 0;
		repeat (60) begin
			@(negedge clock);
			n_busy += (busy === 1'b1);
		end
		chk_range("busy after reset", RESET_HOLD_CYC - 1, RESET_HOLD_CYC + 2, n_busy);
		// Parallel modes: every word select piece, bus enable on request
		for (int m = 0; m < 3; m++) begin
			mode <= mode_t'(m);
			word_select <= 2'h0;
			convert(60);
			chk_range("busy cycles", CONV_CYC + 2, BUSY_MAX_CYC, n_busy);
			chk_word("bus at busy fall", pack(m, 0, cur), last_data);
			rd_n <= 1'b0;
			for (int ws = 1; ws <= m + (m == 2); ws++) begin
				word_select <= 2'(ws);
				@(posedge clock);
				@(negedge clock);
				chk_word("bus piece", pack(m, ws, cur), data_out);
			end
			@(posedge clock);
			@(negedge clock);
			chk_word("bus enable", 18'h1, data_oe);
			@(posedge clock);
			rd_n <= 1'b1;
		end
		// Serial read after convert at every divider
		mode <= MODE_SERIAL;
		for (int d = 0; d < 4; d++) begin
			serial_clock_divider <= 2'(d);
			convert(320);
			chk_range("sync after conversion", CONV_CYC + 1, 60, n_sync);
			chk_range("sclk period ns", pmin[d], pmax[d], host_period * 10);
			chk_range("busy ns", CONV_CYC * 10, bmax[d], n_busy * 10);
			chk_range("sync to busy low", 1, 2, n_busy - n_sync_end);
			chk_range("sync to first sclk", 1, 8, host_lead);
		end
		// Deselect in mid-frame floats the serial pins and loses the word
		fork
			convert(320);
			begin
				repeat (60) @(posedge clock);
				cs_n <= 1'b1;
				@(posedge clock);
				@(negedge clock);
				chk_word("oe after deselect", 18'h0, {frame_sync_oe, sclk_oe, serial_data_oe});
				void'(expect_q.pop_front());
			end
		join
		cs_n <= 1'b0;
		@(posedge clock);
		@(negedge clock);
		chk_word("oe after select", 18'h7, {frame_sync_oe, sclk_oe, serial_data_oe});
		// Read during convert: first conversion has nothing to send
		reset <= 1'b1;
		@(posedge clock);
		reset <= 1'b0;
		read_during_convert <= 1'b1;
		convert(60);
		chk_range("first frame sync", 0, 0, n_sync);
		convert(80);
		chk_range("sync after start", SYNC_RDC_CYC, SYNC_RDC_CYC + 1, n_sync);
		chk_range("busy cycles", CONV_CYC + 2, BUSY_MAX_CYC, n_busy);
		chk_range("sclk period ns", 8, 20, host_period * 10);
		summarize();
	end
endmodule : adc_readout_timing_test

// ### adc_timing_pkg.sv
// Purpose: Shared constants and types for the converter sequencing and readout block.
// Assumes: A 100 MHz clock; every figure below is turned into whole clock cycles.
// Notes: Cycle counts derive from the nanosecond figures, except the serial clock half periods, which a new clock rate also needs edited.
// Contract
// - Busy lasts at most 550 ns, except read-after-convert.
// - Busy falls at least 10 ns after conversion end.
// - Device reset drives busy high after ~10 ns.
// - Busy stays high ~500 ns after device reset.
// - Parallel data valid within 550 ns of start.
// - Parallel data valid before busy falls.
// - Parallel bus access gives valid data within 20 ns.
// - Serial clock driven within 10 ns of select.
// - Deselect floats sync, clock and data within 10 ns.
// - Read-during-convert sync ~135 ns after start.
// - First serial clock edge follows sync by 2 ns.
// - Read-after-convert sync comes after conversion end.
// - Read-after-convert busy drops ~13 ns after sync.
// - Divider settings give minimum periods 8/16/32/64 ns.
// - Divider settings give maximum periods 20/40/70/135 ns.
// - Read-after-convert busy at most 0.84/1.14/1.72/2.88 us.
package adc_timing_pkg;

	// Clock and word size
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int DATA_BITS = 18;
	typedef logic [DATA_BITS-1:0] sample_t; // One conversion result
	typedef logic [1:0] mode_t; // Readout mode pins
	typedef logic [7:0] count_t; // Sequencing counter
	typedef logic [3:0] half_t; // Serial clock half period in cycles

	// Readout modes
	localparam mode_t MODE_PAR18 = 2'h0;
	localparam mode_t MODE_PAR16 = 2'h1;
	localparam mode_t MODE_BYTE = 2'h2;
	localparam mode_t MODE_SERIAL = 2'h3;

	// Internal conversion length, kept short so read-after-convert fits its busy limit
	localparam int CONV_NS = 350;
	localparam int CONV_CYC = CONV_NS / CLOCK_PERIOD_NS;
	// Busy limit outside read-after-convert, rounded down
	localparam int BUSY_MAX_NS = 550;
	localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLOCK_PERIOD_NS;
	// Parallel data valid limit after start
	localparam int DATA_VALID_NS = 550;
	localparam int DATA_VALID_CYC = DATA_VALID_NS / CLOCK_PERIOD_NS;
	// Busy hold after device reset
	localparam int RESET_HOLD_NS = 500;
	localparam int RESET_HOLD_CYC = RESET_HOLD_NS / CLOCK_PERIOD_NS;
	// Start to sync in read-during-convert
	localparam int SYNC_RDC_NS = 135;
	localparam int SYNC_RDC_CYC = SYNC_RDC_NS / CLOCK_PERIOD_NS;

	// Serial clock half periods: 20, 40, 60 and 120 ns full periods
	localparam half_t HALF_RDC = 4'h1;
	localparam half_t HALF_DIV0 = 4'h1;
	localparam half_t HALF_DIV1 = 4'h2;
	localparam half_t HALF_DIV2 = 4'h3;
	localparam half_t HALF_DIV3 = 4'h6;

	// Read-after-convert busy limits per divider setting
	localparam int RAC_BUSY0_NS = 840;
	localparam int RAC_BUSY1_NS = 1140;
	localparam int RAC_BUSY2_NS = 1720;
	localparam int RAC_BUSY3_NS = 2880;

	// Conversion sequencer states
	typedef enum logic [2:0] {
		C_IDLE = 3'h0,
		C_CONV = 3'h1,
		C_PUSH = 3'h2,
		C_WAIT_DATA = 3'h3,
		C_WAIT_FRAME = 3'h4,
		C_SETTLE = 3'h5,
		C_RESET = 3'h6
	} conv_state_e;

	// Serial frame states
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_SYNC = 2'h1,
		S_SHIFT = 2'h2
	} ser_state_e;

endpackage : adc_timing_pkg

// ### half_period_timer.sv
// Purpose: Pulses once every given number of cycles to pace the serial clock.
// Assumes: half_cycles is at least one and stable while running.
// Notes: Restart aligns the first pulse with the start of a frame.
`timescale 1ns/100ps
module half_period_timer (
	input wire logic clock, // System clock
	input wire logic reset, // Synchronous reset
	input wire logic restart, // Clear the count
	input wire logic [3:0] half_cycles, // Cycles between pulses
	output logic tick // One-cycle pulse
);
	logic [3:0] cnt_reg, cnt_next; // Cycles since last pulse

	// Count up, wrap on the pulse
	always_comb begin
		tick = 1'b0;
		cnt_next = cnt_reg + 1'b1;
		if (restart) begin
			cnt_next = '0;
		end else if (cnt_reg == half_cycles - 1'b1) begin
			tick = 1'b1;
			cnt_next = '0;
		end
	end

	// Counter register
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule : half_period_timer

// ### serial_host.sv
// Purpose: Host side model that captures master serial frames from the converter.
// Assumes: Data is taken on the serial clock rising edge while frame sync is high.
// Notes: Only complete 18-bit frames are reported; a cut frame is useless to a host.
`timescale 1ns/100ps
module serial_host (
	input wire logic clock, // System clock
	input wire logic reset, // Synchronous reset
	input wire logic sync, // Frame sync from device
	input wire logic sclk, // Serial clock from device
	input wire logic sdata, // Serial data from device
	output adc_timing_pkg::sample_t word, // Captured word
	output logic word_valid, // One pulse per complete frame
	output int period, // Last serial clock period in cycles
	output int lead // Cycles from sync rise to first clock rise
);
	import adc_timing_pkg::*;
	logic sclk_d = 1'b0; // Previous serial clock, for edge detect
	logic sync_d = 1'b0; // Previous frame sync
	int bits = 0; // Bits taken in this frame
	int since = 0; // Cycles since the last frame event
	sample_t shift; // Assembly register

	// Capture MSB first and time the clock edges
	always @(posedge clock) begin
		sclk_d <= sclk;
		sync_d <= sync;
		word_valid <= 1'b0;
		since <= since + 1;
		if (reset) begin
			bits <= 0;
		end else if (sync && !sync_d) begin
			bits <= 0;
			since <= 1;
		end else if (sync && sclk && !sclk_d) begin
			shift <= {shift[DATA_BITS-2:0], sdata};
			bits <= bits + 1;
			since <= 1;
			if (bits == 0) begin
				lead <= since;
			end else begin
				period <= since;
			end
		end else if (!sync && sync_d && bits == DATA_BITS) begin
			// Frame closed with all bits in hand
			word <= shift;
			word_valid <= 1'b1;
		end
	end
endmodule : serial_host

// ### two_entry_buffer.sv
// Purpose: Small result buffer with valid and ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full and empty come straight from the occupancy count.
`timescale 1ns/100ps
module two_entry_buffer #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 2
) (
	input wire logic clock, // System clock
	input wire logic reset, // Synchronous reset
	input wire logic [WIDTH-1:0] in_data, // Word to store
	input wire logic in_valid, // Writer offers a word
	output logic in_ready, // Room for a word
	output logic [WIDTH-1:0] out_data, // Oldest word
	output logic out_valid, // A word is held
	input wire logic out_ready // Reader takes the word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [PW-1:0] wr_reg, wr_next; // Write pointer
	logic [PW-1:0] rd_reg, rd_next; // Read pointer
	logic [PW:0] cnt_reg, cnt_next; // Occupancy
	logic push, pop; // Handshakes

	assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];

	// Pointer and count update; wrap is explicit since depth need not be a power of two
	always_comb begin
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (push) begin
			wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
		end
		if (pop) begin
			rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
		end
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clock) begin
		if (reset) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage needs no reset; out_valid guards it
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

endmodule : two_entry_buffer
